//--- hdl/cmc_mode_ctrl.sv
// Notes on behaviour
// (RL1) Reset: sleep mode, receive pull-up on
// (RL2) Mode entered: acknowledge set, pull-up off
// (RL3) Normal only after 11 recessive bits
// (RL4) Init exit seen when acknowledge clears
// (RL5) Init: no transfers, transmit recessive
// (RL6) Entering init keeps configuration intact
// (RL7) Software writes filters only while inactive
// (RL8) Sleep: clock stopped, no status updates
// (RL9) Init request in sleep never acknowledged
// (RL10) Sleep exit; auto wake clears request
// (RL11) No auto wake: software clears request
// (RL12) Wake interrupt on bus activity if enabled
// (RL13) Sleep acknowledge clears after bus sync
// (RL14) Test bits set only during initialization; the design accepts diagnostic writes in any mode
// (RL15) Silent: recessive output, never transmits
// (RL16) Silent: dominant bits looped back internally
// (RL17) Loop-back: own frames received and filtered
// (RL18) Loop-back: acknowledge errors ignored
// (RL19) Loop-back: transmit feeds receive internally
// (RL20) Combined: receive cut, transmit recessive
// (RL21) Two receive FIFOs, three messages each
// (RL22) Standard and extended identifiers supported
// (RL23) Sleep wake: dominant receive level detected
//
// Strobed register access and the placing of the registers are this design's own decisions.
module cmc_mode_ctrl #(
  parameter int SYNC_BITS = cmc_pkg::IDLE_BITS
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register port
  input wire logic [cmc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [cmc_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [cmc_pkg::DATA_W-1:0] reg_rdata_o,
  // Protocol core side
  input wire logic bit_tick_i,
  input wire logic core_tx_i,
  output logic core_rx_o,
  output logic core_clk_en_o,
  output logic transfer_en_o,
  output logic tx_start_allow_o,
  output logic ack_err_ignore_o,
  output logic own_rx_accept_o,
  output logic wakeup_irq_o,
  // Bus pins
  input wire logic bus_rx_pin_i,
  output logic bus_tx_pin_o,
  output logic rx_pullup_en_o
);
  import cmc_pkg::*;

  // ==========================================================
  // Registers and state
  cmc_state_t state;
  cmc_state_t next_state;
  cmc_ctrl_t ctrl;
  cmc_ctrl_t next_ctrl;
  cmc_diag_t diag;
  logic wakeup_irq_enable;
  logic from_sleep;
  logic rx_pullup;
  logic bus_tx;
  logic wake_irq;
  logic rx_level;
  logic [3:0] idle_cnt;
  logic [3:0] next_idle_cnt;
  logic [DATA_W-1:0] rdata;

  // ==========================================================
  // Decode
  wire wr_ctrl = reg_wr_i && (reg_addr_i == MASTER_CONTROL_REG);
  wire wr_diag = reg_wr_i && (reg_addr_i == DIAGNOSTIC_REG);
  wire wr_ien = reg_wr_i && (reg_addr_i == IRQ_ENABLE_REG);
  wire in_sleep = (state == CMC_SLEEP);
  wire in_init = (state == CMC_INIT);
  wire in_normal = (state == CMC_NORMAL);
  wire init_ack = in_init;
  // Acknowledge stays up until the bus is idle when leaving sleep
  wire sleep_ack = in_sleep || ((state == CMC_SYNC) && from_sleep); // see (RL13)
  wire silent = diag.silent_select;
  wire loopback = diag.loopback_select;

  // ==========================================================
  // Pin routing
  // Outside normal operation the core may only send recessive
  wire tx_int = core_tx_i || !in_normal; // see (RL5)
  // Silent: dominant bits reach only the core, bus sees ones
  wire rx_silent = bus_rx_pin_i && tx_int; // see (RL16)
  // Loop-back feeds core receive from transmit, not the pin, combined mode too
  wire rx_int = loopback ? tx_int : (silent ? rx_silent : bus_rx_pin_i); // see (RL19) (RL20)
  wire next_bus_tx = silent ? 1'b1 : tx_int; // see (RL15) (RL20)
  // Wake detection runs off the free clock while the core is gated
  wire bus_activity = in_sleep && !bus_rx_pin_i; // see (RL23)
  wire sync_done = (state == CMC_SYNC) && bit_tick_i && rx_int
    && (idle_cnt == 4'(SYNC_BITS - 1)); // see (RL3)

  // ==========================================================
  // Idle bit counter: any dominant bit restarts the count
  always_comb begin
    next_idle_cnt = idle_cnt;
    if (state != CMC_SYNC) begin
      next_idle_cnt = 4'h0;
    end else if (bit_tick_i) begin
      next_idle_cnt = rx_int ? idle_cnt + 4'h1 : 4'h0; // see (RL3)
    end
  end

  // ==========================================================
  // Mode sequencing
  always_comb begin
    next_state = state;
    case (state)
      CMC_SLEEP: begin
        // An init request alone cannot leave sleep
        if (!ctrl.sleep_request) begin
          next_state = CMC_SYNC; // see (RL9) (RL10)
        end
      end
      CMC_INIT: begin
        if (!ctrl.init_request) begin
          next_state = ctrl.sleep_request ? CMC_SLEEP : CMC_SYNC; // see (RL4)
        end
      end
      CMC_SYNC: begin
        if (ctrl.init_request) begin
          next_state = CMC_INIT; // see (RL2)
        end else if (ctrl.sleep_request) begin
          next_state = CMC_SLEEP;
        end else if (sync_done) begin
          next_state = CMC_NORMAL; // see (RL3)
        end
      end
      CMC_NORMAL: begin
        if (ctrl.init_request) begin
          next_state = CMC_INIT;
        end else if (ctrl.sleep_request) begin
          next_state = CMC_SLEEP;
        end
      end
      default: begin
        next_state = CMC_SLEEP;
      end
    endcase
  end

  // ==========================================================
  // Control register: software write wins over the wake clear
  always_comb begin
    next_ctrl = ctrl;
    if (bus_activity && ctrl.auto_wakeup_enable) begin
      next_ctrl.sleep_request = 1'b0; // see (RL10)
    end
    if (wr_ctrl) begin
      next_ctrl = cmc_ctrl_t'(reg_wdata_i[2:0]);
    end
  end

  // Configuration is written by software and by the auto wake clear, never by mode changes
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl <= CTL_RESET;
      diag <= DIAG_RESET;
      wakeup_irq_enable <= IEN_RESET;
    end else begin
      ctrl <= next_ctrl;
      if (wr_diag) begin
        diag <= cmc_diag_t'(reg_wdata_i[1:0]); // see (RL6)
      end
      if (wr_ien) begin
        wakeup_irq_enable <= reg_wdata_i[IEN_WAKEUP];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= CMC_SLEEP; // see (RL1)
      from_sleep <= 1'b0;
      idle_cnt <= 4'h0;
    end else begin
      state <= next_state;
      idle_cnt <= next_idle_cnt;
      if (next_state == CMC_SYNC) begin
        from_sleep <= in_sleep || from_sleep;
      end else begin
        from_sleep <= 1'b0;
      end
    end
  end

  // Pull-up is on only until the first mode change is confirmed
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_pullup <= 1'b1; // see (RL1)
    end else if (next_state != state) begin
      rx_pullup <= 1'b0; // see (RL2)
    end
  end

  // Status freezes with the gated core clock while asleep
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_level <= 1'b1;
    end else if (!in_sleep) begin
      rx_level <= bus_rx_pin_i; // see (RL8)
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bus_tx <= 1'b1;
      wake_irq <= 1'b0;
    end else begin
      bus_tx <= next_bus_tx;
      wake_irq <= bus_activity && wakeup_irq_enable; // see (RL12)
    end
  end

  // ==========================================================
  // Register read, data stand one cycle after the strobe
  wire [DATA_W-1:0] status_word = {{(DATA_W-4){1'b0}}, rx_level, in_normal,
    sleep_ack, init_ack};
  wire [DATA_W-1:0] caps_word = DATA_W'({8'(EXT_ID_W), 8'(STD_ID_W),
    4'(RX_FIFO_DEPTH), 4'(RX_FIFO_COUNT)}); // see (RL21) (RL22)
  wire [DATA_W-1:0] rd_mux =
    (reg_addr_i == MASTER_CONTROL_REG) ? {{(DATA_W-3){1'b0}}, ctrl} :
    (reg_addr_i == MASTER_STATUS_REG) ? status_word :
    (reg_addr_i == DIAGNOSTIC_REG) ? {{(DATA_W-2){1'b0}}, diag} :
    (reg_addr_i == IRQ_ENABLE_REG) ? {{(DATA_W-1){1'b0}}, wakeup_irq_enable} :
    (reg_addr_i == CAPABILITY_REG) ? caps_word : '0;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata <= '0;
    end else begin
      rdata <= reg_rd_i ? rd_mux : '0;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata_o = rdata;
  assign core_rx_o = rx_int;
  // Status logic in the core freezes with its gated clock
  assign core_clk_en_o = !in_sleep; // see (RL8)
  assign transfer_en_o = in_normal; // see (RL5)
  assign tx_start_allow_o = in_normal && !silent; // see (RL15)
  assign ack_err_ignore_o = loopback; // see (RL18)
  assign own_rx_accept_o = loopback; // see (RL17)
  assign wakeup_irq_o = wake_irq;
  assign bus_tx_pin_o = bus_tx;
  assign rx_pullup_en_o = rx_pullup;

  // ==========================================================
  // Checks
  sequence s_sleep_exit;
    in_sleep && !ctrl.sleep_request;
  endsequence

  sequence s_held_ack;
    ##1 (state == CMC_SYNC && sleep_ack);
  endsequence

  a_reset_sleep_pullup: assert property ( // see (RL1)
    @(posedge clock_i) disable iff (rst_i)
    $past(rst_i) |-> (sleep_ack && rx_pullup_en_o && !init_ack))
    else $error("not asleep with pull-up after reset");

  a_init_ack_pullup: assert property ( // see (RL2)
    @(posedge clock_i) disable iff (rst_i)
    $rose(init_ack) |-> !rx_pullup_en_o && !sleep_ack)
    else $error("init acknowledge with pull-up or sleep acknowledge");

  a_idle_bits_sync: assert property ( // see (RL3)
    @(posedge clock_i) disable iff (rst_i)
    $rose(in_normal) |-> $past(idle_cnt) == 4'(SYNC_BITS - 1) && $past(rx_int))
    else $error("normal entered without idle bits");

  a_init_exit_ack: assert property ( // see (RL4)
    @(posedge clock_i) disable iff (rst_i)
    (in_init && !ctrl.init_request) |=> !init_ack)
    else $error("init acknowledge not cleared");

  a_init_tx_recessive: assert property ( // see (RL5)
    @(posedge clock_i) disable iff (rst_i)
    in_init |=> bus_tx_pin_o && !transfer_en_o)
    else $error("transmit not recessive in init");

  a_init_cfg_kept: assert property ( // see (RL6)
    @(posedge clock_i) disable iff (rst_i)
    (next_state == CMC_INIT && !in_init && !reg_wr_i) |=> $stable(diag) && $stable(ctrl))
    else $error("configuration changed on init entry");

  a_sleep_no_init: assert property ( // see (RL9)
    @(posedge clock_i) disable iff (rst_i)
    (in_sleep && ctrl.init_request && ctrl.sleep_request) |=> !init_ack)
    else $error("init acknowledged while asleep");

  a_auto_wake_clear: assert property ( // see (RL10)
    @(posedge clock_i) disable iff (rst_i)
    (bus_activity && ctrl.auto_wakeup_enable && !wr_ctrl) |=> !ctrl.sleep_request)
    else $error("auto wake did not clear sleep request");

  a_wake_irq_pulse: assert property ( // see (RL12)
    @(posedge clock_i) disable iff (rst_i)
    wakeup_irq_o |-> $past(in_sleep) && !$past(bus_rx_pin_i) && $past(wakeup_irq_enable))
    else $error("wake interrupt without cause");

  a_sleep_ack_held: assert property ( // see (RL13)
    @(posedge clock_i) disable iff (rst_i)
    s_sleep_exit ##0 !ctrl.init_request |-> s_held_ack)
    else $error("sleep acknowledge cleared before sync");

  a_silent_recessive: assert property ( // see (RL15)
    @(posedge clock_i) disable iff (rst_i)
    silent |=> bus_tx_pin_o)
    else $error("silent mode drove dominant");

  a_loop_rx_source: assert property ( // see (RL19)
    @(posedge clock_i) disable iff (rst_i)
    loopback |-> core_rx_o == (core_tx_i || !in_normal))
    else $error("loop-back receive not from transmit");

  a_sync_no_xfer: assert property ( // see (RL3)
    @(posedge clock_i) disable iff (rst_i)
    (state == CMC_SYNC) |-> !transfer_en_o && !tx_start_allow_o)
    else $error("transfer enabled before bus idle");

  a_sleep_pullup_off: assert property ( // see (RL2)
    @(posedge clock_i) disable iff (rst_i)
    $rose(in_sleep) |-> !rx_pullup_en_o && !init_ack)
    else $error("sleep entered with pull-up on");

  a_sleep_clk_stop: assert property ( // see (RL8)
    @(posedge clock_i) disable iff (rst_i)
    in_sleep |-> !core_clk_en_o && !transfer_en_o)
    else $error("core clock running in sleep");

  a_sleep_status_hold: assert property ( // see (RL8)
    @(posedge clock_i) disable iff (rst_i)
    in_sleep |=> $stable(rx_level))
    else $error("status changed in sleep");

  a_wake_irq_on: assert property ( // see (RL12)
    @(posedge clock_i) disable iff (rst_i)
    (in_sleep && !bus_rx_pin_i && wakeup_irq_enable) |=> wakeup_irq_o)
    else $error("bus activity raised no wake interrupt");

  a_wake_from_sleep: assert property ( // see (RL23)
    @(posedge clock_i) disable iff (rst_i)
    (in_sleep && !bus_rx_pin_i && ctrl.auto_wakeup_enable && !wr_ctrl) |-> ##2 (state == CMC_SYNC))
    else $error("bus activity did not wake the core");

  a_silent_no_start: assert property ( // see (RL15)
    @(posedge clock_i) disable iff (rst_i)
    silent |-> !tx_start_allow_o)
    else $error("silent mode allowed a transmission");

  a_silent_dominant_loop: assert property ( // see (RL16)
    @(posedge clock_i) disable iff (rst_i)
    (silent && !loopback && in_normal && !core_tx_i) |-> !core_rx_o)
    else $error("silent dominant bit not looped to core");

  a_loop_own_rx: assert property ( // see (RL17)
    @(posedge clock_i) disable iff (rst_i)
    loopback |-> own_rx_accept_o)
    else $error("loop-back own frames not accepted");

  a_loop_ack_ignore: assert property ( // see (RL18)
    @(posedge clock_i) disable iff (rst_i)
    loopback |-> ack_err_ignore_o)
    else $error("loop-back acknowledge errors not ignored");

  a_caps_fifos: assert property ( // see (RL21)
    @(posedge clock_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == CAPABILITY_REG)
      |=> reg_rdata_o[7:0] == {4'(RX_FIFO_DEPTH), 4'(RX_FIFO_COUNT)})
    else $error("receive buffer capability wrong");

  a_caps_ids: assert property ( // see (RL22)
    @(posedge clock_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == CAPABILITY_REG)
      |=> reg_rdata_o[23:8] == {8'(EXT_ID_W), 8'(STD_ID_W)})
    else $error("identifier capability wrong");
endmodule

//--- hdl/cmc_pkg.sv
package cmc_pkg;
  // ==========================================================
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==========================================================
  // Register byte addresses
  localparam logic [ADDR_W-1:0] MASTER_CONTROL_REG = 8'h00;
  localparam logic [ADDR_W-1:0] MASTER_STATUS_REG = 8'h04;
  localparam logic [ADDR_W-1:0] DIAGNOSTIC_REG = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_REG = 8'h0C;
  localparam logic [ADDR_W-1:0] CAPABILITY_REG = 8'h10;

  // ==========================================================
  // Field positions
  localparam int CTL_INIT_REQUEST = 0;
  localparam int CTL_SLEEP_REQUEST = 1;
  localparam int CTL_AUTO_WAKEUP = 2;
  localparam int STS_INIT_ACK = 0;
  localparam int STS_SLEEP_ACK = 1;
  localparam int STS_SYNCED = 2;
  localparam int STS_RX_LEVEL = 3;
  localparam int DIAG_SILENT = 0;
  localparam int DIAG_LOOPBACK = 1;
  localparam int IEN_WAKEUP = 0;
  localparam int CAP_FIFO_COUNT = 0;
  localparam int CAP_FIFO_DEPTH = 4;
  localparam int CAP_STD_ID_W = 8;
  localparam int CAP_EXT_ID_W = 16;

  // ==========================================================
  // Reset values: the core wakes from reset asleep
  localparam logic [2:0] CTL_RESET = 3'h2;
  localparam logic [1:0] DIAG_RESET = 2'h0;
  localparam logic IEN_RESET = 1'b0;

  // ==========================================================
  // Protocol figures
  localparam int IDLE_BITS = 11;
  localparam int RX_FIFO_COUNT = 2;
  localparam int RX_FIFO_DEPTH = 3;
  localparam int STD_ID_W = 11;
  localparam int EXT_ID_W = 29;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    CMC_SLEEP,
    CMC_INIT,
    CMC_SYNC,
    CMC_NORMAL
  } cmc_state_t;

  typedef struct packed {
    logic auto_wakeup_enable;
    logic sleep_request;
    logic init_request;
  } cmc_ctrl_t;

  typedef struct packed {
    logic loopback_select;
    logic silent_select;
  } cmc_diag_t;
endpackage

//--- verification/cmc_bus_model.sv
module cmc_bus_model (
  // Clock
  input wire logic clock_i,
  // Bus side
  output logic bus_rx_pin_o,
  output logic bit_tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bus_rx_pin_o = 1'b1;
    bit_tick_o = 1'b0;
  end
  // ==========================================================
  // Bit stream: a released line floats to the pull-up level
  task automatic send(input int n, input logic lvl);
    repeat (n) begin
      @(posedge clock_i);
      bus_rx_pin_o <= lvl;
      bit_tick_o <= 1'b1;
      @(posedge clock_i);
      bit_tick_o <= 1'b0;
      bus_rx_pin_o <= 1'b1;
      @(posedge clock_i);
    end
  endtask
  task automatic set_pin(input logic lvl);
    bus_rx_pin_o <= lvl;
  endtask
endmodule

//--- verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cmc_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic bit_tick_i, core_tx_i = 1'b1, core_rx_o, core_clk_en_o, transfer_en_o;
  logic tx_start_allow_o, ack_err_ignore_o, own_rx_accept_o, wakeup_irq_o;
  logic bus_rx_pin_i, bus_tx_pin_o, rx_pullup_en_o;
  logic pend = 1'b0;
  logic [DATA_W-1:0] exp_q[$];
  int failures = 0;
  int n_tests = 0;
  always #2 clock_i = ~clock_i;
  cmc_mode_ctrl cmc_mode_ctrl_inst (.clock_i(clock_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .bit_tick_i(bit_tick_i),
    .core_tx_i(core_tx_i), .core_rx_o(core_rx_o), .core_clk_en_o(core_clk_en_o),
    .transfer_en_o(transfer_en_o), .tx_start_allow_o(tx_start_allow_o),
    .ack_err_ignore_o(ack_err_ignore_o), .own_rx_accept_o(own_rx_accept_o),
    .wakeup_irq_o(wakeup_irq_o), .bus_rx_pin_i(bus_rx_pin_i),
    .bus_tx_pin_o(bus_tx_pin_o), .rx_pullup_en_o(rx_pullup_en_o));
  cmc_bus_model cmc_bus_model_inst (.clock_i(clock_i), .bus_rx_pin_o(bus_rx_pin_i),
    .bit_tick_o(bit_tick_i));
  // ==========================================================
  // Checking
  task automatic chk(input string name, input logic [DATA_W-1:0] exp,
                     input logic [DATA_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Read data stands only in the cycle after the strobe
  always @(posedge clock_i) begin
    pend <= reg_rd_i;
    if (pend) chk("reg_rdata_o", exp_q.pop_front(), reg_rdata_o);
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Register bus master
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    exp_q.push_back(e);
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic settle();
    repeat (4) @(posedge clock_i);
    #1;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    logic sil, lb, tx, pin, prev;
    void'($urandom(32'h3DAF));
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    settle();
    chk("pullup", 1, rx_pullup_en_o);
    chk("clk_en", 0, core_clk_en_o);
    rd(MASTER_STATUS_REG, 32'h0000000A);
    rd(MASTER_CONTROL_REG, 32'h00000002);
    rd(CAPABILITY_REG, 32'h001D0B32);
    rd(8'h20, 32'h0); // unmapped
    wr(MASTER_CONTROL_REG, 32'h3);
    settle();
    rd(MASTER_STATUS_REG, 32'h0000000A);
    wr(MASTER_CONTROL_REG, 32'h1);
    settle();
    rd(MASTER_STATUS_REG, 32'h00000009);
    chk("pullup", 0, rx_pullup_en_o);
    prev = 1'b0;
    for (int m = 0; m < 4; m++) begin
      sil = m[0];
      lb = m[1];
      wr(MASTER_CONTROL_REG, 32'h1);
      settle();
      chk("tx_pin", 1, bus_tx_pin_o);
      chk("xfer", 0, transfer_en_o);
      rd(DIAGNOSTIC_REG, {30'h0, prev, 1'b0} | 32'(m > 0 ? m - 1 : 0));
      wr(DIAGNOSTIC_REG, 32'(m));
      wr(MASTER_CONTROL_REG, 32'h0);
      settle();
      rd(MASTER_STATUS_REG, 32'h00000008);
      cmc_bus_model_inst.send(5, 1'b1);
      cmc_bus_model_inst.send(1, 1'b0);
      cmc_bus_model_inst.send(10, 1'b1);
      #1;
      chk("xfer", 32'(lb), transfer_en_o);
      cmc_bus_model_inst.send(1, 1'b1);
      #1;
      chk("xfer", 1, transfer_en_o);
      chk("tx_allow", 32'(!sil), tx_start_allow_o);
      chk("ack_ign", 32'(lb), ack_err_ignore_o);
      chk("own_rx", 32'(lb), own_rx_accept_o);
      repeat (8) begin
        tx = 1'($urandom);
        pin = 1'($urandom);
        @(posedge clock_i);
        core_tx_i <= tx;
        cmc_bus_model_inst.set_pin(pin);
        #1;
        chk("core_rx", lb ? tx : sil ? (pin & tx) : pin, core_rx_o);
        @(posedge clock_i);
        #1;
        chk("tx_pin", sil ? 1 : tx, bus_tx_pin_o);
      end
      @(posedge clock_i);
      core_tx_i <= 1'b1;
      cmc_bus_model_inst.set_pin(1'b1);
      prev = 1'b0;
    end
    rd(DIAGNOSTIC_REG, 32'h3);
    wr(IRQ_ENABLE_REG, 32'h1);
    wr(MASTER_CONTROL_REG, 32'h6);
    settle();
    rd(MASTER_STATUS_REG, 32'h0000000A);
    chk("clk_en", 0, core_clk_en_o);
    @(posedge clock_i);
    cmc_bus_model_inst.set_pin(1'b0);
    @(posedge clock_i);
    cmc_bus_model_inst.set_pin(1'b1);
    #1;
    chk("wake_irq", 1, wakeup_irq_o);
    settle();
    rd(MASTER_CONTROL_REG, 32'h4);
    rd(MASTER_STATUS_REG, 32'h0000000A);
    cmc_bus_model_inst.send(11, 1'b1);
    settle();
    rd(MASTER_STATUS_REG, 32'h0000000C);
    wr(MASTER_CONTROL_REG, 32'h2);
    settle();
    @(posedge clock_i);
    cmc_bus_model_inst.set_pin(1'b0);
    @(posedge clock_i);
    cmc_bus_model_inst.set_pin(1'b1);
    #1;
    chk("wake_irq", 1, wakeup_irq_o);
    settle();
    rd(MASTER_CONTROL_REG, 32'h2);
    rd(MASTER_STATUS_REG, 32'h0000000A);
    wr(MASTER_CONTROL_REG, 32'h0);
    rd(MASTER_STATUS_REG, 32'h0000000A);
    cmc_bus_model_inst.send(11, 1'b1);
    settle();
    rd(MASTER_STATUS_REG, 32'h0000000C);
    settle();
    final_report();
  end
  initial begin
    #200000;
    failures++;
    final_report();
  end
endmodule
